// ### hw/evd_defines.vh
`ifndef EVD_DEFINES_VH
`define EVD_DEFINES_VH
// ----------------------------------------
// vector base register number and vector offsets
// ----------------------------------------
`define EVD_VTB_IPR 8'h11
`define EVD_OFF_MCHK 12'h004
`define EVD_OFF_ACV 12'h020
`define EVD_OFF_TNV 12'h024
`define EVD_OFF_ARITH 12'h034
`define EVD_OFF_CHANGE_TO_KERNEL 12'h040
`define EVD_OFF_CRD 12'h054
`define EVD_OFF_MEMERR 12'h060
`define EVD_OFF_TIM0 12'h078
`define EVD_OFF_TIM1 12'h07c
`define EVD_OFF_SWBASE 12'h080
`define EVD_OFF_ITIM 12'h0c0
`define EVD_OFF_EMUL 12'h0c8
`define EVD_OFF_EMULC 12'h0cc
`define EVD_OFF_CRX 12'h0f8
`define EVD_OFF_CTX 12'h0fc
`define EVD_OFF_MSP 12'h104
`define EVD_OFF_NET 12'h10c
// ----------------------------------------
// priority levels
// ----------------------------------------
`define EVD_IPL_CRD 5'h1a
`define EVD_IPL_MEMERR 5'h1d
`define EVD_IPL_DEV 5'h14
`define EVD_IPL_ITIM 5'h16
`define EVD_IPL_MCHK 5'h1f
// ----------------------------------------
// dispatch types and parameter counts
// ----------------------------------------
`define EVD_TYP_FAULT 2'h0
`define EVD_TYP_TRAP 2'h1
`define EVD_TYP_INT 2'h2
`define EVD_TYP_ABORT 2'h3
`define EVD_NP_ACV 4'h2
`define EVD_NP_ARITH 4'h1
`define EVD_NP_CHM 4'h1
`define EVD_NP_EMUL 4'ha
`define EVD_NP_MCHK 4'h4
`define EVD_NP_NONE 4'h0
// ----------------------------------------
// error bit positions and reset values
// ----------------------------------------
`define EVD_MS_TAG 0
`define EVD_MS_DATA 1
`define EVD_MS_RDPAR 6
`define EVD_MC_WRPAR 7
`define EVD_MC_CRD 29
`define EVD_MC_UNC 31
`define EVD_DS_MNXM 0
`define EVD_DS_NOGNT 2
`define EVD_DS_TMO 4
`define EVD_DS_DPAR 5
`define EVD_DS_NXM 7
`define EVD_RST_8 8'h00
`define EVD_RST_32 32'h00000000
`endif

// ### hw/evd_exception_unit.v
`include "evd_defines.vh"
module evd_exception_unit
(
  input wire clk_i,
  input wire sys_rst_i,
  input wire ipr_wr_i,
  input wire [7:0] ipr_num_i,
  input wire [31:0] ipr_wdata_i,
  input wire exc_acv_i,
  input wire exc_tnv_i,
  input wire exc_arith_i,
  input wire exc_arith_fault_i,
  input wire [1:0] exc_chm_mode_i,
  input wire exc_chm_i,
  input wire exc_emul_start_i,
  input wire exc_emul_cont_i,
  input wire [14:0] sw_int_req_i,
  input wire timer0_req_i,
  input wire timer1_req_i,
  input wire interval_timer_int_line_i,
  input wire console_rx_req_i,
  input wire console_tx_req_i,
  input wire mass_storage_req_i,
  input wire network_req_i,
  input wire [4:0] cur_ipl_i,
  input wire err_bus_parity_i,
  input wire err_bus_write_i,
  input wire err_cache_tag_i,
  input wire err_cache_data_i,
  input wire err_bp_nxm_i,
  input wire err_bp_no_slave_acknowledge_i,
  input wire err_bp_no_grant_i,
  input wire err_bp_dev_parity_i,
  input wire err_bus_timeout_i,
  input wire err_mem_nxm_i,
  input wire err_mem_corr_i,
  input wire err_mem_uncorr_i,
  input wire err_dma_i,
  input wire err_demand_read_i,
  input wire [7:0] ms_clear_i,
  input wire [7:0] dma_clear_i,
  input wire [31:0] mc_clear_i,
  output reg dispatch_o,
  output reg [31:0] vector_addr_o,
  output reg [11:0] vector_off_o,
  output reg [1:0] vector_type_o,
  output reg [3:0] param_count_o,
  output reg [4:0] vector_ipl_o,
  output reg first_part_done_o,
  output reg machine_check_o,
  output wire corrected_read_int_line_o,
  output wire memory_error_int_line_o,
  output wire [31:0] vector_base_o,
  output wire [7:0] memory_system_error_o,
  output wire [7:0] dma_system_error_o,
  output wire [31:0] memory_controller_error_o
);

// ----------------------------------------
// input synchronisers
// ----------------------------------------
// all requests come from pins or other logic off this block; two stages each
localparam NIN = 45;
wire [NIN-1:0] raw_in;
reg [NIN-1:0] sync1_reg;
reg [NIN-1:0] sync2_reg;
assign raw_in = {exc_acv_i, exc_tnv_i, exc_arith_i, exc_arith_fault_i, exc_chm_mode_i,
  exc_chm_i, exc_emul_start_i, exc_emul_cont_i, sw_int_req_i, timer0_req_i,
  timer1_req_i, interval_timer_int_line_i, console_rx_req_i, console_tx_req_i,
  mass_storage_req_i, network_req_i, err_bus_parity_i, err_bus_write_i,
  err_cache_tag_i, err_cache_data_i, err_bp_nxm_i, err_bp_no_slave_acknowledge_i,
  err_bp_no_grant_i, err_bp_dev_parity_i, err_bus_timeout_i, err_mem_nxm_i,
  err_mem_corr_i, err_mem_uncorr_i, err_dma_i, err_demand_read_i};

always @(posedge clk_i or posedge sys_rst_i)
begin
  if (sys_rst_i)
  begin
    sync1_reg <= {NIN{1'b0}};
    sync2_reg <= {NIN{1'b0}};
  end
  else
  begin
    sync1_reg <= raw_in;
    sync2_reg <= sync1_reg;
  end
end

wire s_acv = sync2_reg[44];
wire s_tnv = sync2_reg[43];
wire s_arith = sync2_reg[42];
wire s_arith_fault = sync2_reg[41];
wire [1:0] s_chm_mode = sync2_reg[40:39];
wire s_chm = sync2_reg[38];
wire s_emul_start = sync2_reg[37];
wire s_emul_cont = sync2_reg[36];
wire [14:0] s_sw = sync2_reg[35:21];
wire s_tim0 = sync2_reg[20];
wire s_tim1 = sync2_reg[19];
wire s_itim = sync2_reg[18];
wire s_crx = sync2_reg[17];
wire s_ctx = sync2_reg[16];
wire s_msp = sync2_reg[15];
wire s_net = sync2_reg[14];
wire s_par = sync2_reg[13];
wire s_wr = sync2_reg[12];
wire s_tag = sync2_reg[11];
wire s_dat = sync2_reg[10];
wire s_bnxm = sync2_reg[9];
wire s_nosack = sync2_reg[8];
wire s_nogrant = sync2_reg[7];
wire s_dpar = sync2_reg[6];
wire s_tmo = sync2_reg[5];
wire s_mnxm = sync2_reg[4];
wire s_corr = sync2_reg[3];
wire s_unc = sync2_reg[2];
wire s_dma = sync2_reg[1];
wire s_dread = sync2_reg[0];

// ----------------------------------------
// vector table base
// ----------------------------------------
reg [31:0] vtb_reg;
always @(posedge clk_i or posedge sys_rst_i)
begin
  if (sys_rst_i)
    vtb_reg <= `EVD_RST_32;
  else if (ipr_wr_i && ipr_num_i == `EVD_VTB_IPR)
    vtb_reg <= {ipr_wdata_i[31:2], 2'b00};
end
assign vector_base_o = vtb_reg;

// ----------------------------------------
// error status
// ----------------------------------------
reg [7:0] ms_reg;
reg [7:0] ds_reg;
reg [31:0] mc_reg;
reg [7:0] ms_set;
reg [7:0] ds_set;
reg [31:0] mc_set;
always @*
begin
  ms_set = 8'h00;
  ds_set = 8'h00;
  mc_set = 32'h00000000;
  ms_set[`EVD_MS_RDPAR] = s_par & ~s_wr;
  mc_set[`EVD_MC_WRPAR] = s_par & s_wr;
  ms_set[`EVD_MS_TAG] = s_tag;
  ms_set[`EVD_MS_DATA] = s_dat;
  ds_set[`EVD_DS_NXM] = s_bnxm;
  ds_set[`EVD_DS_NOGNT] = s_nogrant;
  ds_set[`EVD_DS_DPAR] = s_dpar;
  ds_set[`EVD_DS_TMO] = s_dma & (s_tmo | s_unc);
  ds_set[`EVD_DS_MNXM] = s_dma & s_mnxm;
  mc_set[`EVD_MC_CRD] = s_corr;
  mc_set[`EVD_MC_UNC] = s_unc;
end

// set wins over a clear in the same cycle
always @(posedge clk_i or posedge sys_rst_i)
begin
  if (sys_rst_i)
  begin
    ms_reg <= `EVD_RST_8;
    ds_reg <= `EVD_RST_8;
    mc_reg <= `EVD_RST_32;
  end
  else
  begin
    ms_reg <= (ms_reg & ~ms_clear_i) | ms_set;
    ds_reg <= (ds_reg & ~dma_clear_i) | ds_set;
    mc_reg <= (mc_reg & ~mc_clear_i) | mc_set;
  end
end
assign memory_system_error_o = ms_reg;
assign dma_system_error_o = ds_reg;
assign memory_controller_error_o = mc_reg;

// ----------------------------------------
// error response
// ----------------------------------------
// no slave acknowledge has no status bit, but still reaches a response
wire any_err = s_par | s_tag | s_dat | s_bnxm | s_nosack | s_nogrant | s_dpar
  | s_tmo | s_mnxm | s_unc;
// fatal errors on a demand read without dma abort the instruction; others post an interrupt
wire mchk_ev = any_err & s_dread & ~s_dma;
wire memerr_ev = any_err & ~mchk_ev;
wire crd_ev = s_corr & ~s_unc;
reg crd_pend_reg;
reg memerr_pend_reg;

assign corrected_read_int_line_o = ~crd_pend_reg;
assign memory_error_int_line_o = ~memerr_pend_reg;

// ----------------------------------------
// dispatch selection
// ----------------------------------------
localparam ST_IDLE = 2'b01;
localparam ST_SENT = 2'b10;
reg [1:0] state_reg;
reg [1:0] state_next;
reg sel_v;
reg [11:0] sel_off;
reg [1:0] sel_typ;
reg [3:0] sel_np;
reg [4:0] sel_ipl;
reg sel_fpd;
reg sel_mchk;
reg sel_crd;
reg sel_mem;
integer i;

function [11:0] sw_off;
  input [3:0] lvl;
  begin
    sw_off = `EVD_OFF_SWBASE + {6'h00, lvl, 2'b00};
  end
endfunction

// highest level first; exceptions preempt interrupts
always @*
begin
  sel_v = 1'b0;
  sel_off = 12'h000;
  sel_typ = `EVD_TYP_INT;
  sel_np = `EVD_NP_NONE;
  sel_ipl = 5'h00;
  sel_fpd = 1'b0;
  sel_mchk = 1'b0;
  sel_crd = 1'b0;
  sel_mem = 1'b0;
  for (i = 1; i <= 15; i = i + 1)
  begin
    if (s_sw[i-1] && cur_ipl_i < i[4:0])
    begin
      sel_v = 1'b1;
      sel_off = sw_off(i[3:0]);
      sel_ipl = i[4:0];
    end
  end
  if ((s_tim0 | s_tim1 | s_crx | s_ctx | s_msp | s_net) && cur_ipl_i < `EVD_IPL_DEV)
  begin
    sel_v = 1'b1;
    sel_ipl = `EVD_IPL_DEV;
    sel_off = s_tim0 ? `EVD_OFF_TIM0 : s_tim1 ? `EVD_OFF_TIM1 : s_crx ? `EVD_OFF_CRX :
      s_ctx ? `EVD_OFF_CTX : s_msp ? `EVD_OFF_MSP : `EVD_OFF_NET;
  end
  if (s_itim && cur_ipl_i < `EVD_IPL_ITIM)
  begin
    sel_v = 1'b1;
    sel_ipl = `EVD_IPL_ITIM;
    sel_off = `EVD_OFF_ITIM;
  end
  if (crd_pend_reg && cur_ipl_i < `EVD_IPL_CRD)
  begin
    sel_v = 1'b1;
    sel_ipl = `EVD_IPL_CRD;
    sel_off = `EVD_OFF_CRD;
    sel_crd = 1'b1;
  end
  if (memerr_pend_reg && cur_ipl_i < `EVD_IPL_MEMERR)
  begin
    sel_v = 1'b1;
    sel_ipl = `EVD_IPL_MEMERR;
    sel_off = `EVD_OFF_MEMERR;
    sel_crd = 1'b0;
    sel_mem = 1'b1;
  end
  if (s_emul_cont | s_emul_start | s_chm | s_arith | s_tnv | s_acv | mchk_ev)
  begin
    sel_v = 1'b1;
    sel_ipl = cur_ipl_i;
    sel_crd = 1'b0;
    sel_mem = 1'b0;
    if (mchk_ev)
    begin
      sel_off = `EVD_OFF_MCHK;
      sel_typ = `EVD_TYP_ABORT;
      sel_np = `EVD_NP_MCHK;
      sel_mchk = 1'b1;
    end
    else if (s_acv)
    begin
      sel_off = `EVD_OFF_ACV;
      sel_typ = `EVD_TYP_FAULT;
      sel_np = `EVD_NP_ACV;
    end
    else if (s_tnv)
    begin
      sel_off = `EVD_OFF_TNV;
      sel_typ = `EVD_TYP_FAULT;
      sel_np = `EVD_NP_ACV;
    end
    else if (s_arith)
    begin
      sel_off = `EVD_OFF_ARITH;
      sel_typ = s_arith_fault ? `EVD_TYP_FAULT : `EVD_TYP_TRAP;
      sel_np = `EVD_NP_ARITH;
    end
    else if (s_chm)
    begin
      sel_off = `EVD_OFF_CHANGE_TO_KERNEL + {8'h00, s_chm_mode, 2'b00};
      sel_typ = `EVD_TYP_TRAP;
      sel_np = `EVD_NP_CHM;
    end
    else if (s_emul_start)
    begin
      sel_off = `EVD_OFF_EMUL;
      sel_typ = `EVD_TYP_FAULT;
      sel_np = `EVD_NP_EMUL;
    end
    else
    begin
      sel_off = `EVD_OFF_EMULC;
      sel_typ = `EVD_TYP_FAULT;
      sel_fpd = 1'b1;
    end
  end
  // every offset chosen above is a used one; gaps in the table are never produced
  state_next = ST_IDLE;
  case (state_reg)
    ST_IDLE: state_next = sel_v ? ST_SENT : ST_IDLE;
    ST_SENT: state_next = ST_IDLE;
    default: state_next = ST_IDLE;
  endcase
end

// one dispatch per two cycles so synchronised levels can drop between them
always @(posedge clk_i or posedge sys_rst_i)
begin
  if (sys_rst_i)
  begin
    state_reg <= ST_IDLE;
    dispatch_o <= 1'b0;
    vector_addr_o <= `EVD_RST_32;
    vector_off_o <= 12'h000;
    vector_type_o <= `EVD_TYP_FAULT;
    param_count_o <= `EVD_NP_NONE;
    vector_ipl_o <= 5'h00;
    first_part_done_o <= 1'b0;
    machine_check_o <= 1'b0;
    crd_pend_reg <= 1'b0;
    memerr_pend_reg <= 1'b0;
  end
  else
  begin
    state_reg <= state_next;
    dispatch_o <= (state_reg == ST_IDLE) && sel_v;
    machine_check_o <= (state_reg == ST_IDLE) && sel_mchk;
    if (state_reg == ST_IDLE && sel_v)
    begin
      vector_addr_o <= vtb_reg + {20'h00000, sel_off};
      vector_off_o <= sel_off;
      vector_type_o <= sel_typ;
      param_count_o <= sel_np;
      vector_ipl_o <= sel_ipl;
      first_part_done_o <= sel_fpd;
    end
    crd_pend_reg <= crd_ev | (crd_pend_reg & ~(state_reg == ST_IDLE && sel_crd));
    memerr_pend_reg <= memerr_ev | (memerr_pend_reg & ~(state_reg == ST_IDLE && sel_mem));
  end
end

endmodule // evd_exception_unit

// ### sim/evd_err_src.sv
module evd_err_src
(
  input wire logic go_i,
  input wire logic [3:0] kind_i,
  input wire logic [2:0] qual_i,
  output logic [13:0] err_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // error source lines
  // ----------------------------------------
  // bit 1 doubles as the write qualifier of a parity error, 12 and 13 qualify dma and demand;
  // a released source returns to idle low, so a stale level cannot pass for an error
  assign err_o = go_i ? ({qual_i[2:1], 12'h001 << kind_i} | {12'h000, qual_i[0], 1'b0}) : 14'h0000;
endmodule // evd_err_src

// ### sim/evd_exception_unit_props.sv
module evd_exception_unit_props
(
  input wire clk_i,
  input wire sys_rst_i,
  input wire err_cache_tag_i,
  input wire [7:0] ms_clear_i,
  input wire dispatch_o,
  input wire [31:0] vector_addr_o,
  input wire [11:0] vector_off_o,
  input wire [1:0] vector_type_o,
  input wire [3:0] param_count_o,
  input wire [4:0] vector_ipl_o,
  input wire first_part_done_o,
  input wire [31:0] vector_base_o,
  input wire [7:0] memory_system_error_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] kept_reg;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ----------------------------------------
  // helper
  // ----------------------------------------
  // status bits that were set and not cleared; they must still be set one edge later
  always @(posedge clk_i or posedge sys_rst_i)
    if (sys_rst_i)
      kept_reg <= 8'h00;
    else
      kept_reg <= memory_system_error_o & ~ms_clear_i;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_base_plus_off: assert property (dispatch_o |-> vector_addr_o == vector_base_o + {20'h0, vector_off_o})
    else $error("vector address not base plus offset");
  a_acv_tnv_fault: assert property (dispatch_o && vector_off_o inside {12'h020, 12'h024} |-> vector_type_o == 2'h0 && param_count_o == 4'h2)
    else $error("access or translation fault fields wrong");
  a_arith_one: assert property (dispatch_o && vector_off_o == 12'h034 |-> param_count_o == 4'h1 && vector_type_o <= 2'h1)
    else $error("arithmetic fields wrong");
  a_mode_trap: assert property (dispatch_o && vector_off_o inside {[12'h040:12'h04c]} |-> vector_type_o == 2'h1 && param_count_o == 4'h1)
    else $error("change mode fields wrong");
  a_crd_level: assert property (dispatch_o && vector_off_o == 12'h054 |-> vector_ipl_o == 5'h1a && param_count_o == 4'h0 && vector_type_o == 2'h2)
    else $error("corrected read fields wrong");
  a_memerr_level: assert property (dispatch_o && vector_off_o == 12'h060 |-> vector_ipl_o == 5'h1d && param_count_o == 4'h0 && vector_type_o == 2'h2)
    else $error("memory error fields wrong");
  a_device_level: assert property (dispatch_o && vector_off_o inside {12'h078, 12'h07c, 12'h0f8, 12'h0fc, 12'h104, 12'h10c} |-> vector_ipl_o == 5'h14)
    else $error("device level wrong");
  a_soft_level: assert property (dispatch_o && vector_off_o inside {[12'h084:12'h0bc]} |-> vector_ipl_o == vector_off_o[6:2])
    else $error("software level wrong");
  a_emul_start: assert property (dispatch_o && vector_off_o == 12'h0c8 |-> param_count_o == 4'ha && !first_part_done_o)
    else $error("emulation start fields wrong");
  a_emul_cont: assert property (dispatch_o && vector_off_o == 12'h0cc |-> param_count_o == 4'h0 && first_part_done_o)
    else $error("emulation continue fields wrong");
  a_no_unused: assert property (dispatch_o |-> !(vector_off_o inside {12'h030, [12'h038:12'h03c], 12'h050, [12'h058:12'h05c], [12'h064:12'h074], 12'h080, 12'h0c4, [12'h0d0:12'h0f4]}))
    else $error("dispatch through unused offset");
  a_tag_flag: assert property ($rose(err_cache_tag_i) |-> ##3 memory_system_error_o[0])
    else $error("tag parity bit not set");
  a_status_hold: assert property ((memory_system_error_o & kept_reg) == kept_reg)
    else $error("status bit lost without clear");
  a_one_pulse: assert property (dispatch_o |=> !dispatch_o)
    else $error("dispatch longer than one cycle");
endmodule // evd_exception_unit_props

bind evd_exception_unit evd_exception_unit_props u_props (.*);

// ### sim/evd_exception_unit_bench.sv
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module evd_exception_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [3:0] src; logic [1:0] md; logic [11:0] off; logic [1:0] typ;
    logic [3:0] np; logic [4:0] interrupt_priority_level;} evd_vrow_t;
  typedef struct packed {logic [3:0] kind; logic [2:0] q; logic [7:0] ms; logic [7:0] ds;
    logic [31:0] mc; logic [1:0] ln;} evd_erow_t;
  // ----------------------------------------
  // tables
  // ----------------------------------------
  // md drives the mode and, through bit 0, the fault flag of an arithmetic exception
  evd_vrow_t vrows [17] = '{'{0, 0, 'h020, 0, 2, 0}, '{1, 0, 'h024, 0, 2, 0},
    '{2, 1, 'h034, 0, 1, 0}, '{2, 0, 'h034, 1, 1, 0}, '{3, 0, 'h040, 1, 1, 0},
    '{3, 1, 'h044, 1, 1, 0}, '{3, 2, 'h048, 1, 1, 0}, '{3, 3, 'h04c, 1, 1, 0},
    '{4, 0, 'h0c8, 0, 10, 0}, '{5, 0, 'h0cc, 0, 0, 0}, '{6, 0, 'h078, 2, 0, 'h14},
    '{7, 0, 'h07c, 2, 0, 'h14}, '{8, 0, 'h0c0, 2, 0, 'h16}, '{9, 0, 'h0f8, 2, 0, 'h14},
    '{10, 0, 'h0fc, 2, 0, 'h14}, '{11, 0, 'h104, 2, 0, 'h14}, '{12, 0, 'h10c, 2, 0, 'h14}};
  // q is demand, dma, write; ln is memory error line then corrected line, 0 means unchecked
  evd_erow_t erows [15] = '{'{0, 0, 'h40, 0, 0, 1}, '{0, 1, 0, 0, 'h80, 1}, '{2, 0, 1, 0, 0, 1},
    '{3, 0, 2, 0, 0, 1}, '{4, 0, 0, 'h80, 0, 1}, '{5, 0, 0, 0, 0, 1}, '{6, 0, 0, 4, 0, 1},
    '{7, 0, 0, 'h20, 0, 1}, '{8, 2, 0, 'h10, 0, 1}, '{8, 0, 0, 0, 0, 0}, '{9, 2, 0, 1, 0, 1},
    '{9, 0, 0, 0, 0, 0}, '{10, 0, 0, 0, 'h20000000, 2}, '{11, 2, 0, 'h10, 'h80000000, 1},
    '{11, 4, 0, 0, 'h80000000, 3}};
  logic clk_i = 0, sys_rst_i = 1, ipr_wr_i = 0, go = 0;
  logic [31:0] req = 0, ipr_wdata_i = 0, mc_clear_i = 0;
  logic [1:0] md = 0;
  logic [2:0] q = 0;
  logic [3:0] kind = 0;
  logic [4:0] cur_ipl_i = 0;
  logic [7:0] ipr_num_i = 0, ms_clear_i = 0, dma_clear_i = 0;
  logic [13:0] err;
  logic dispatch_o, first_part_done_o, machine_check_o;
  logic corrected_read_int_line_o, memory_error_int_line_o;
  logic [31:0] vector_addr_o, vector_base_o, memory_controller_error_o;
  logic [11:0] vector_off_o;
  logic [1:0] vector_type_o;
  logic [3:0] param_count_o;
  logic [4:0] vector_ipl_o;
  logic [7:0] memory_system_error_o, dma_system_error_o;
  evd_vrow_t cap;
  int bad_count = 0, num_checks = 0, disp_cnt = 0, mchk_cnt = 0, n0;
  evd_err_src u_src (.go_i(go), .kind_i(kind), .qual_i(q), .err_o(err));
  evd_exception_unit uut (.exc_acv_i(req[0]), .exc_tnv_i(req[1]), .exc_arith_i(req[2]),
    .exc_chm_i(req[3]), .exc_emul_start_i(req[4]), .exc_emul_cont_i(req[5]),
    .timer0_req_i(req[6]), .timer1_req_i(req[7]), .interval_timer_int_line_i(req[8]),
    .console_rx_req_i(req[9]), .console_tx_req_i(req[10]), .mass_storage_req_i(req[11]),
    .network_req_i(req[12]), .sw_int_req_i(req[27:13]), .exc_arith_fault_i(md[0]),
    .exc_chm_mode_i(md), .err_bus_parity_i(err[0]), .err_bus_write_i(err[1]),
    .err_cache_tag_i(err[2]), .err_cache_data_i(err[3]), .err_bp_nxm_i(err[4]),
    .err_bp_no_slave_acknowledge_i(err[5]), .err_bp_no_grant_i(err[6]), .err_bp_dev_parity_i(err[7]),
    .err_bus_timeout_i(err[8]), .err_mem_nxm_i(err[9]), .err_mem_corr_i(err[10]),
    .err_mem_uncorr_i(err[11]), .err_dma_i(err[12]), .err_demand_read_i(err[13]), .*);
  initial
    forever #2 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    if (dispatch_o === 1'b1)
      disp_cnt++;
    if (machine_check_o === 1'b1)
      mchk_cnt++;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  // a held request re-dispatches, so a one-cycle pulse is sent to get a single dispatch
  task automatic fire(input logic [31:0] bits, input logic [1:0] m);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= bits;
    md <= m;
    @(posedge clk_i);
    req <= 0;
    do begin @(negedge clk_i); n++; end while (dispatch_o !== 1'b1 && n < 20);
    cap = '{0, 0, vector_off_o, vector_type_o, param_count_o, vector_ipl_o};
    repeat (6) @(posedge clk_i);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (4000) @(posedge clk_i);
    bad_count++;
    test_done;
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 0;
    @(negedge clk_i);
    `CHK("reset", {4'b1100, 80'h0}, {corrected_read_int_line_o, memory_error_int_line_o, dispatch_o, machine_check_o, memory_system_error_o, dma_system_error_o, memory_controller_error_o, vector_base_o})
    @(posedge clk_i);
    ipr_num_i <= 8'h12;
    ipr_wdata_i <= 32'hffff0000;
    ipr_wr_i <= 1;
    @(posedge clk_i);
    ipr_num_i <= 8'h11;
    ipr_wdata_i <= 32'h00012347;
    @(posedge clk_i);
    ipr_wr_i <= 0;
    @(negedge clk_i);
    `CHK("base", 32'h00012344, vector_base_o)
    foreach (vrows[i])
    begin
      fire(32'h1 << vrows[i].src, vrows[i].md);
      `CHK("vector", {vrows[i].off, vrows[i].typ, vrows[i].np}, {cap.off, cap.typ, cap.np})
      if (vrows[i].typ == 2'h2)
        `CHK("level", vrows[i].interrupt_priority_level, cap.interrupt_priority_level)
      `CHK("addr", 32'h00012344 + {20'h0, vrows[i].off}, vector_addr_o)
    end
    for (int l = 1; l < 16; l++)
    begin
      fire(32'h1 << (12 + l), 0);
      `CHK("soft", {12'h080 + 12'(4 * l), 5'(l)}, {cap.off, cap.interrupt_priority_level})
    end
    fire(32'h3, 0);
    `CHK("priority", 12'h020, cap.off)
    n0 = disp_cnt;
    @(posedge clk_i);
    cur_ipl_i <= 5'h14;
    fire(32'h40, 0);
    `CHK("masked", n0, disp_cnt)
    @(posedge clk_i);
    cur_ipl_i <= 5'h13;
    fire(32'h40, 0);
    `CHK("unmasked", 12'h078, cap.off)
    @(posedge clk_i);
    cur_ipl_i <= 5'h1f;
    // interrupts stay pending under the top level so the lines can be seen low
    foreach (erows[i])
    begin
      @(posedge clk_i);
      kind <= erows[i].kind;
      q <= erows[i].q;
      go <= 1;
      repeat (2) @(posedge clk_i);
      go <= 0;
      repeat (5) @(posedge clk_i);
      @(negedge clk_i);
      `CHK("status", {erows[i].ms, erows[i].ds, erows[i].mc}, {memory_system_error_o, dma_system_error_o, memory_controller_error_o})
      if (erows[i].ln != 2'b00)
        `CHK("lines", erows[i].ln, {memory_error_int_line_o, corrected_read_int_line_o})
      @(posedge clk_i);
      ms_clear_i <= 8'hff;
      dma_clear_i <= 8'hff;
      mc_clear_i <= 32'hffffffff;
      cur_ipl_i <= 5'h00;
      @(posedge clk_i);
      ms_clear_i <= 8'h00;
      dma_clear_i <= 8'h00;
      mc_clear_i <= 32'h00000000;
      repeat (8) @(posedge clk_i);
      cur_ipl_i <= 5'h1f;
      @(negedge clk_i);
      `CHK("cleared", {48'h0, 2'b11}, {memory_system_error_o, dma_system_error_o, memory_controller_error_o, memory_error_int_line_o, corrected_read_int_line_o})
    end
    `CHK("machine check", 1, mchk_cnt)
    test_done;
  end
endmodule // evd_exception_unit_bench
